// ### hdl/cld_consts.svh
// constants of the character display instruction decoder
`ifndef CLD_CONSTS_SVH
`define CLD_CONSTS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLD_CLK_PERIOD_NS 10
`define CLD_EXEC_TIME_NS 100000
`define CLD_LONG_TIME_NS 4100000

// ------------------------------------------------------------
// instruction classes: position of the highest set bit
// ------------------------------------------------------------
`define CLD_BIT_DISP_ADDR 7
`define CLD_BIT_PAT_ADDR 6
`define CLD_BIT_FUNC 5
`define CLD_BIT_SHIFT 4
`define CLD_BIT_ONOFF 3
`define CLD_BIT_ENTRY 2
`define CLD_BIT_HOME 1
`define CLD_BIT_CLEAR 0

// ------------------------------------------------------------
// fields inside instructions
// ------------------------------------------------------------
`define CLD_FLD_INC 1
`define CLD_FLD_SHEN 0
`define CLD_FLD_DISP 2
`define CLD_FLD_CUR 1
`define CLD_FLD_BLINK 0
`define CLD_FLD_SC 3
`define CLD_FLD_RL 2
`define CLD_FLD_DL 4
`define CLD_FLD_N 3
`define CLD_FLD_F 2

// ------------------------------------------------------------
// values
// ------------------------------------------------------------
`define CLD_SPACE_CODE 8'h20
`define CLD_HOME_ADDR 7'h00
`define CLD_LAST_DISP_ADDR 7'h7f
`define CLD_INIT_LEN 3'h4
`define CLD_INIT_CLEAR 8'h01
`define CLD_INIT_FUNC 8'h30
`define CLD_INIT_ONOFF 8'h08
`define CLD_INIT_ENTRY 8'h06
`define CLD_RST_BUS8 1'b1
`define CLD_RST_INC 1'b1

`endif

// ### hdl/cld_pkg.sv
// types and instruction decode of the character display instruction decoder
package cld_pkg;
`include "cld_consts.svh"

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_clear = 2'h1,
    st_wait = 2'h3
  } cld_state_t;

  typedef enum logic [3:0] {
    op_none, op_clear, op_home, op_entry, op_onoff,
    op_shift, op_func, op_pat_addr, op_disp_addr
  } cld_op_t;

  // highest set bit picks the instruction; lower bits are fields or ignored
  function automatic cld_op_t cld_decode(input logic [7:0] c);
    if (c[`CLD_BIT_DISP_ADDR]) return op_disp_addr;
    else if (c[`CLD_BIT_PAT_ADDR]) return op_pat_addr;
    else if (c[`CLD_BIT_FUNC]) return op_func;
    else if (c[`CLD_BIT_SHIFT]) return op_shift;
    else if (c[`CLD_BIT_ONOFF]) return op_onoff;
    else if (c[`CLD_BIT_ENTRY]) return op_entry;
    else if (c[`CLD_BIT_HOME]) return op_home;
    else if (c[`CLD_BIT_CLEAR]) return op_clear;
    else return op_none;
  endfunction
endpackage

// ### hdl/cld_decoder.sv
// instruction decoder and executor of a character display controller, with its write fifo
`timescale 1ns/1ps
`include "cld_consts.svh"

// ------------------------------------------------------------
// fifo
// ------------------------------------------------------------
module cld_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------------------
// decoder top
// ------------------------------------------------------------
module cld_decoder #(
  parameter int unsigned EXEC_CYCLES = `CLD_EXEC_TIME_NS / `CLD_CLK_PERIOD_NS,
  parameter int unsigned LONG_CYCLES = `CLD_LONG_TIME_NS / `CLD_CLK_PERIOD_NS,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // host bus pins
  input wire logic host_enable,
  input wire logic register_select,
  input wire logic host_read,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  // flow
  output logic host_write_ready,
  // status
  output logic busy_flag,
  output logic [6:0] address_counter,
  output logic pattern_select,
  output logic [6:0] display_shift,
  // configuration
  output logic entry_increment,
  output logic entry_display_shift,
  output logic display_on,
  output logic cursor_on,
  output logic cursor_blink,
  output logic bus_width_bit,
  output logic two_line,
  output logic tall_font
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic en_s1, en_s2, en_q, rs_s1, rs_s2, rw_s1, rw_s2;
  logic [7:0] d_s1, d_s2;
  logic en_rise, en_fall, nib_phase, rd_done;
  logic [3:0] hi_nib;
  logic [7:0] rd_byte, rd_val, mem_q;
  logic push_valid, fifo_valid, fifo_pop;
  logic [8:0] push_data, fifo_data;
  logic [7:0] disp_mem [0:127];
  logic [7:0] pat_mem [0:63];
  cld_pkg::cld_state_t state;
  cld_pkg::cld_op_t op;
  logic [6:0] clr_addr;
  logic [31:0] wait_cnt;
  logic [2:0] init_idx;
  logic init_active, exec_go, exec_rs;
  logic [7:0] exec_code, init_code;
  logic [6:0] next_ac;
  logic [6:0] next_shift;

  // ------------------------------------------------------------
  // pin synchronisers and strobe edges
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {en_s1, en_s2, en_q, rs_s1, rs_s2, rw_s1, rw_s2} <= 7'h00;
      d_s1 <= 8'h00;
      d_s2 <= 8'h00;
    end else begin
      {en_s1, rs_s1, rw_s1, d_s1} <= {host_enable, register_select, host_read, host_data_in};
      {en_s2, rs_s2, rw_s2, d_s2} <= {en_s1, rs_s1, rw_s1, d_s1};
      en_q <= en_s2;
    end
  end

  assign en_rise = en_s2 && !en_q;
  assign en_fall = !en_s2 && en_q;

  // ------------------------------------------------------------
  // host access
  // ------------------------------------------------------------
  // the text and pattern memories are read asynchronously; the byte is caught at strobe rise
  assign mem_q = pattern_select ? pat_mem[address_counter[5:0]] : disp_mem[address_counter];
  assign rd_val = rs_s2 ? mem_q : {busy_flag, address_counter};
  assign rd_done = en_fall && rw_s2 && (bus_width_bit || nib_phase);
  assign push_valid = en_fall && !rw_s2 && (bus_width_bit || nib_phase);
  assign push_data = bus_width_bit ? {rs_s2, d_s2} : {rs_s2, hi_nib, d_s2[7:4]};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nib_phase <= 1'b0;
      hi_nib <= 4'h0;
      rd_byte <= 8'h00;
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= en_s2 && rw_s2;
      // a status read may meet a function set in flight; its capture must not lose to it
      if (en_rise && rw_s2) begin
        if (bus_width_bit || !nib_phase) begin
          rd_byte <= rd_val;
          host_data_out <= bus_width_bit ? rd_val : {rd_val[7:4], 4'h0};
        end else begin
          host_data_out <= {rd_byte[3:0], 4'h0};
        end
      end
      if (en_fall && !bus_width_bit && !nib_phase && !rw_s2) begin
        hi_nib <= d_s2[7:4];
      end
      if (exec_go && !exec_rs && op == cld_pkg::op_func) begin
        nib_phase <= 1'b0;
      end else if (en_fall && !bus_width_bit) begin
        nib_phase <= !nib_phase;
      end
    end
  end

  // a write that finds the fifo full is dropped; host_write_ready shows it
  cld_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst(sys_rst),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(host_write_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // ------------------------------------------------------------
  // executor
  // ------------------------------------------------------------
  always_comb begin
    case (init_idx)
      3'h0: init_code = `CLD_INIT_CLEAR;
      3'h1: init_code = `CLD_INIT_FUNC;
      3'h2: init_code = `CLD_INIT_ONOFF;
      default: init_code = `CLD_INIT_ENTRY;
    endcase
  end

  assign init_active = (init_idx != `CLD_INIT_LEN);
  // the executor only drains while idle, so queued writes back up into the fifo
  assign exec_go = (state == cld_pkg::st_idle) && (init_active || fifo_valid);
  assign fifo_pop = exec_go && !init_active;
  assign exec_rs = init_active ? 1'b0 : fifo_data[8];
  assign exec_code = init_active ? init_code : fifo_data[7:0];
  assign op = cld_pkg::cld_decode(exec_code);
  assign busy_flag = (state != cld_pkg::st_idle) || init_active || fifo_valid;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_idx <= 3'h0;
    end else if (exec_go && init_active) begin
      init_idx <= init_idx + 3'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= cld_pkg::st_idle;
      clr_addr <= 7'h00;
      wait_cnt <= 32'h0;
    end else begin
      case (state)
        cld_pkg::st_idle: begin
          if (exec_go && !exec_rs && op == cld_pkg::op_clear) begin
            state <= cld_pkg::st_clear;
            clr_addr <= 7'h00;
            wait_cnt <= LONG_CYCLES - 32'd129;
          end else if (exec_go) begin
            state <= cld_pkg::st_wait;
            wait_cnt <= (!exec_rs && op == cld_pkg::op_home) ? LONG_CYCLES - 32'd1
                                                             : EXEC_CYCLES - 32'd1;
          end
        end
        cld_pkg::st_clear: begin
          clr_addr <= clr_addr + 7'h01;
          if (clr_addr == `CLD_LAST_DISP_ADDR) begin
            state <= cld_pkg::st_wait;
          end
        end
        cld_pkg::st_wait: begin
          if (wait_cnt == 32'h0) begin
            state <= cld_pkg::st_idle;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        default: state <= cld_pkg::st_idle;
      endcase
    end
  end

  // ------------------------------------------------------------
  // memories
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (state == cld_pkg::st_clear) begin
      disp_mem[clr_addr] <= `CLD_SPACE_CODE;
    end else if (exec_go && exec_rs) begin
      if (pattern_select) begin
        pat_mem[address_counter[5:0]] <= exec_code;
      end else begin
        disp_mem[address_counter] <= exec_code;
      end
    end
  end

  // ------------------------------------------------------------
  // address counter and display shift
  // ------------------------------------------------------------
  // pattern addresses wrap inside six bits so a step never leaks into text space
  always_comb begin
    next_ac = (exec_go && !exec_rs && op == cld_pkg::op_shift) ?
              (exec_code[`CLD_FLD_RL] ? address_counter + 7'h01 : address_counter - 7'h01) :
              (entry_increment ? address_counter + 7'h01 : address_counter - 7'h01);
    if (pattern_select) begin
      next_ac = {1'b0, next_ac[5:0]};
    end
    next_shift = entry_increment ? display_shift + 7'h01 : display_shift - 7'h01;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      address_counter <= `CLD_HOME_ADDR;
      pattern_select <= 1'b0;
      display_shift <= 7'h00;
    end else if (exec_go && exec_rs) begin
      address_counter <= next_ac;
      if (entry_display_shift) begin
        display_shift <= next_shift;
      end
    end else if (exec_go) begin
      case (op)
        cld_pkg::op_clear: begin
          address_counter <= `CLD_HOME_ADDR;
          pattern_select <= 1'b0;
          display_shift <= 7'h00;
        end
        cld_pkg::op_home: begin
          address_counter <= `CLD_HOME_ADDR;
          pattern_select <= 1'b0;
          display_shift <= 7'h00;
        end
        cld_pkg::op_shift: begin
          if (exec_code[`CLD_FLD_SC]) begin
            display_shift <= exec_code[`CLD_FLD_RL] ? display_shift - 7'h01
                                                    : display_shift + 7'h01;
          end else begin
            address_counter <= next_ac;
          end
        end
        cld_pkg::op_pat_addr: begin
          address_counter <= {1'b0, exec_code[5:0]};
          pattern_select <= 1'b1;
        end
        cld_pkg::op_disp_addr: begin
          address_counter <= exec_code[6:0];
          pattern_select <= 1'b0;
        end
        default: begin
        end
      endcase
    end else if (rd_done && rs_s2) begin
      address_counter <= next_ac;
      if (entry_display_shift) begin
        display_shift <= next_shift;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration bits
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      entry_increment <= `CLD_RST_INC;
      entry_display_shift <= 1'b0;
      {display_on, cursor_on, cursor_blink} <= 3'h0;
      bus_width_bit <= `CLD_RST_BUS8;
      two_line <= 1'b0;
      tall_font <= 1'b0;
    end else if (exec_go && !exec_rs) begin
      case (op)
        cld_pkg::op_entry: begin
          entry_increment <= exec_code[`CLD_FLD_INC];
          entry_display_shift <= exec_code[`CLD_FLD_SHEN];
        end
        cld_pkg::op_onoff: begin
          display_on <= exec_code[`CLD_FLD_DISP];
          cursor_on <= exec_code[`CLD_FLD_CUR];
          cursor_blink <= exec_code[`CLD_FLD_BLINK];
        end
        cld_pkg::op_func: begin
          bus_width_bit <= exec_code[`CLD_FLD_DL];
          two_line <= exec_code[`CLD_FLD_N];
          tall_font <= exec_code[`CLD_FLD_F];
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic go_cmd;
  assign go_cmd = exec_go && !exec_rs;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_clear_walk: assert property (
    go_cmd && op == cld_pkg::op_clear |=> address_counter == 7'h00
      ##127 state == cld_pkg::st_clear ##1 state == cld_pkg::st_wait)
    else $error("clear walk length or address wrong");
  a_home_zero: assert property (
    go_cmd && op == cld_pkg::op_home |=> address_counter == 7'h00 && display_shift == 7'h00)
    else $error("home did not zero address and shift");
  a_entry_load: assert property (
    go_cmd && op == cld_pkg::op_entry |=>
      {entry_increment, entry_display_shift} == $past(exec_code[1:0]))
    else $error("entry bits not loaded");
  a_onoff_load: assert property (
    go_cmd && op == cld_pkg::op_onoff |=>
      {display_on, cursor_on, cursor_blink} == $past(exec_code[2:0]))
    else $error("on/off bits not loaded");
  a_shift_keep: assert property (
    go_cmd && op == cld_pkg::op_shift && exec_code[3] |=> $stable(address_counter))
    else $error("display shift moved the address");
  a_func_load: assert property (
    go_cmd && op == cld_pkg::op_func |=>
      {bus_width_bit, two_line, tall_font} == $past(exec_code[4:2]))
    else $error("function bits not loaded");
  a_pat_addr: assert property (
    go_cmd && op == cld_pkg::op_pat_addr |=>
      pattern_select && address_counter == {1'b0, $past(exec_code[5:0])})
    else $error("pattern address not loaded");
  a_disp_addr: assert property (
    go_cmd && op == cld_pkg::op_disp_addr |=>
      !pattern_select && address_counter == $past(exec_code[6:0]))
    else $error("text address not loaded");
  a_status_read: assert property (
    en_rise && rw_s2 && !rs_s2 && bus_width_bit |=>
      host_data_out == {$past(busy_flag), $past(address_counter)})
    else $error("status read wrong");
  a_data_step: assert property (
    exec_go && exec_rs && entry_increment && !pattern_select |=>
      address_counter == $past(address_counter) + 7'h01)
    else $error("counter did not step after data write");
  a_busy_hold: assert property (
    exec_go |=> busy_flag [*2])
    else $error("busy dropped during execution");

  c_clear: cover property (go_cmd && op == cld_pkg::op_clear);
  c_data_write: cover property (exec_go && exec_rs && pattern_select);
  c_fifo_full: cover property (!host_write_ready);
  c_nibble_read: cover property (rd_done && !bus_width_bit);
endmodule

// ### bench/cld_host_model.sv
// host processor model driving the strobed parallel bus of the decoder
`timescale 1ns/1ps

module cld_host_model (
  // clock
  input wire logic core_clk,
  // bus pins
  output logic host_enable,
  output logic register_select,
  output logic host_read,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe
);
  logic narrow;
  logic oe_mid;

  initial begin
    host_enable = 1'b0;
    register_select = 1'b0;
    host_read = 1'b0;
    host_data_in = 8'h00;
    narrow = 1'b0;
    oe_mid = 1'b0;
  end

  // ------------------------------------------------------------
  // one strobe, everything held over the whole pulse
  // ------------------------------------------------------------
  task automatic strobe(input logic rs, input logic rd, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge core_clk);
    register_select <= rs;
    host_read <= rd;
    host_data_in <= d;
    host_enable <= 1'b1;
    repeat (6) @(posedge core_clk);
    q = host_data_out;
    oe_mid = host_data_oe;
    host_enable <= 1'b0;
    repeat (6) @(posedge core_clk);
    // released lines must not keep the last value
    host_data_in <= ~d;
  endtask

  // whole byte: two strobes on the upper lines when narrow, high nibble first;
  // the unused lower lines carry the other nibble, so ignoring them is exercised
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (narrow) begin
      strobe(rs, rd, d, hi);
      strobe(rs, rd, {d[3:0], d[7:4]}, lo);
      q = {hi[7:4], lo[7:4]};
    end else begin
      strobe(rs, rd, d, q);
    end
  endtask

  // poll the status until not busy; bounded so a stuck flag cannot hang us
  task automatic wait_idle();
    logic [7:0] q;
    for (int i = 0; i < 400; i++) begin
      xfer(1'b0, 1'b1, 8'h00, q);
      if (q[7] === 1'b0) begin
        return;
      end
    end
  endtask
endmodule

// ### bench/testbench.sv
// self-checking testbench of the character display instruction decoder
`timescale 1ns/1ps

module testbench;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] cfg;
    logic [6:0] addr;
    logic pat;
    logic [6:0] sh;
  } cld_tb_row_t;

  logic core_clk;
  logic sys_rst;
  logic host_enable, register_select, host_read;
  logic [7:0] host_data_in, host_data_out;
  logic host_data_oe, host_write_ready, busy_flag, pattern_select;
  logic [6:0] address_counter, display_shift;
  logic entry_increment, entry_display_shift, display_on, cursor_on, cursor_blink;
  logic bus_width_bit, two_line, tall_font;
  logic [7:0] cfg, q;
  int num_errors = 0;
  int n_compared = 0;
  // order: increment, display shift, on, cursor, blink, width, lines, font
  cld_tb_row_t rows [14] = '{
    '{8'h0f, 8'hbc, 7'h00, 1'b0, 7'h00}, '{8'h0a, 8'h94, 7'h00, 1'b0, 7'h00},
    '{8'h05, 8'h54, 7'h00, 1'b0, 7'h00}, '{8'h06, 8'h94, 7'h00, 1'b0, 7'h00},
    '{8'h3f, 8'h97, 7'h00, 1'b0, 7'h00}, '{8'h30, 8'h94, 7'h00, 1'b0, 7'h00},
    '{8'h8a, 8'h94, 7'h0a, 1'b0, 7'h00}, '{8'h14, 8'h94, 7'h0b, 1'b0, 7'h00},
    '{8'h10, 8'h94, 7'h0a, 1'b0, 7'h00}, '{8'h18, 8'h94, 7'h0a, 1'b0, 7'h01},
    '{8'h1f, 8'h94, 7'h0a, 1'b0, 7'h00},
    '{8'h02, 8'h94, 7'h00, 1'b0, 7'h00}, '{8'h7f, 8'h94, 7'h3f, 1'b1, 7'h00},
    '{8'hc5, 8'h94, 7'h45, 1'b0, 7'h00}};

  assign cfg = {entry_increment, entry_display_shift, display_on, cursor_on,
                cursor_blink, bus_width_bit, two_line, tall_font};

  // short execution counts keep the run brief
  cld_decoder #(.EXEC_CYCLES(20), .LONG_CYCLES(300), .FIFO_DEPTH(4)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .host_enable(host_enable),
    .register_select(register_select), .host_read(host_read),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_write_ready(host_write_ready),
    .busy_flag(busy_flag), .address_counter(address_counter),
    .pattern_select(pattern_select), .display_shift(display_shift),
    .entry_increment(entry_increment), .entry_display_shift(entry_display_shift),
    .display_on(display_on), .cursor_on(cursor_on), .cursor_blink(cursor_blink),
    .bus_width_bit(bus_width_bit), .two_line(two_line), .tall_font(tall_font));

  cld_host_model host (
    .core_clk(core_clk), .host_enable(host_enable), .register_select(register_select),
    .host_read(host_read), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic put(input logic rs, input logic [7:0] b);
    host.xfer(rs, 1'b0, b, q);
    host.wait_idle();
    check("idle", {7'h00, busy_flag}, 8'h00);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    check("reset config", cfg, 8'h84);
    check("reset ready", {7'h00, host_write_ready}, 8'h01);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("init busy", {7'h00, busy_flag}, 8'h01);
    host.wait_idle();
    check("init config", cfg, 8'h84);
    check("init counter", {1'b0, address_counter}, 8'h00);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #(400_000);
    num_errors++;
    complete_run();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      put(1'b0, rows[i].cmd);
      check("config", cfg, rows[i].cfg);
      check("counter", {1'b0, address_counter}, {1'b0, rows[i].addr});
      check("memory select", {7'h00, pattern_select}, {7'h00, rows[i].pat});
      check("shift", {1'b0, display_shift}, {1'b0, rows[i].sh});
    end
    // status read while an instruction still runs
    host.xfer(1'b0, 1'b0, 8'h0c, q);
    check("drive on write", {7'h00, host.oe_mid}, 8'h00);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    check("status busy", q, 8'hc5);
    check("drive on read", {7'h00, host.oe_mid}, 8'h01);
    host.wait_idle();
    // text and pattern memory write, read back, counter stepping up
    put(1'b0, 8'hc0);
    put(1'b1, 8'h41);
    put(1'b1, 8'h42);
    check("counter after writes", {1'b0, address_counter}, 8'h42);
    put(1'b0, 8'hc0);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    check("text read", q, 8'h41);
    host.wait_idle();
    check("counter after read", {1'b0, address_counter}, 8'h41);
    put(1'b0, 8'h40);
    put(1'b1, 8'h1f);
    put(1'b0, 8'h40);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    check("pattern read", q, 8'h1f);
    host.wait_idle();
    // stepping down, with the display following each write
    put(1'b0, 8'h05);
    put(1'b0, 8'hc0);
    put(1'b1, 8'h55);
    check("counter down", {1'b0, address_counter}, 8'h3f);
    check("shift on write", {1'b0, display_shift}, 8'h7f);
    put(1'b0, 8'h06);
    // clear holds busy long, then text reads back as spaces
    host.xfer(1'b0, 1'b0, 8'h01, q);
    repeat (250) @(posedge core_clk);
    check("clear busy", {7'h00, busy_flag}, 8'h01);
    host.wait_idle();
    check("clear counter", {1'b0, address_counter}, 8'h00);
    check("clear shift", {1'b0, display_shift}, 8'h00);
    put(1'b0, 8'hc0);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    check("clear text", q, 8'h20);
    host.wait_idle();
    // queue fills behind a long home; the fifth write is refused
    host.xfer(1'b0, 1'b0, 8'h02, q);
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b0, 1'b0, 8'h0c | 8'(i), q);
    end
    check("fifo full", {7'h00, host_write_ready}, 8'h00);
    host.xfer(1'b0, 1'b0, 8'h08, q);
    host.wait_idle();
    check("queued order", cfg, 8'hbc);
    // narrow bus: the width changes before the first poll, so polls follow it at once
    host.xfer(1'b0, 1'b0, 8'h20, q);
    host.narrow = 1'b1;
    host.wait_idle();
    check("narrow width", {7'h00, bus_width_bit}, 8'h00);
    put(1'b0, 8'h0e);
    check("narrow config", cfg, 8'hb0);
    put(1'b0, 8'h8a);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    check("narrow status", q, 8'h0a);
    put(1'b1, 8'h5a);
    put(1'b0, 8'h8a);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    check("narrow data", q, 8'h5a);
    host.wait_idle();
    host.xfer(1'b0, 1'b0, 8'h30, q);
    host.narrow = 1'b0;
    host.wait_idle();
    check("wide again", {7'h00, bus_width_bit}, 8'h01);
    do_reset();
    complete_run();
  end
endmodule
